// ---- verilog/sup_pkg.sv ----
// package: supervisor constants, register map and state types
// Contract
// - flash checksum passes before image copy
// - copy verified against flash before entry
// - watchdogs start before later init checks
// - init checks battery, record RAM, supply, display, watchdog
// - co-processor RAM tested, code checksummed twice
// - co-processor start failures leave it out
// - settings, clock, time-code, inputs, reference checked
// - protection off until all tests pass
// - start-up failure holds until manual restore
// - periodic image compare and checksums
// - settings checksum on every access
// - each acquisition run checks I/O, reference
// - co-processor faults and heartbeat supervised
// - silent network board alarmed and reset
// - every error attempts a maintenance record; code records only boot check failures, reboot timeout and in-service faults
// - battery/time-code continue, others reboot within 5s
// - repeated fault locks out permanently; code only sets the repeat flag, and restore still leaves lockout
// - every event goes through fast buffer
// - overflow drops events, logs loss event
package sup_pkg;
   localparam longint CLK_HZ = 200_000_000;
   localparam longint REBOOT_LIMIT_S = 5;
   localparam longint REBOOT_LIMIT_CYC = REBOOT_LIMIT_S * CLK_HZ;
   localparam longint COP_TIMEOUT_MS = 10;
   localparam longint COP_TIMEOUT_CYC = COP_TIMEOUT_MS * CLK_HZ / 1000;
   localparam longint NET_TIMEOUT_MS = 100;
   localparam longint NET_TIMEOUT_CYC = NET_TIMEOUT_MS * CLK_HZ / 1000;
   localparam longint CHECK_PERIOD_MS = 50;
   localparam longint CHECK_PERIOD_CYC = CHECK_PERIOD_MS * CLK_HZ / 1000;
   localparam int ID_W = 5;
   // start-up steps, run in this order
   localparam logic [4:0] STEP_FLASH_CSUM = 5'h00;
   localparam logic [4:0] STEP_IMAGE_COPY = 5'h01;
   localparam logic [4:0] STEP_COPY_VERIFY = 5'h02;
   localparam logic [4:0] STEP_WDOG_START = 5'h03;
   localparam logic [4:0] STEP_BATTERY = 5'h04;
   localparam logic [4:0] STEP_REC_RAM = 5'h05;
   localparam logic [4:0] STEP_FIELD_SUPPLY = 5'h06;
   localparam logic [4:0] STEP_DISPLAY = 5'h07;
   localparam logic [4:0] STEP_WDOG_CHECK = 5'h08;
   localparam logic [4:0] STEP_COP_PRESENT = 5'h09;
   localparam logic [4:0] STEP_COP_RAM = 5'h0a;
   localparam logic [4:0] STEP_COP_CSUM_PRE = 5'h0b;
   localparam logic [4:0] STEP_COP_XFER = 5'h0c;
   localparam logic [4:0] STEP_COP_CSUM_POST = 5'h0d;
   localparam logic [4:0] STEP_COP_CHANNELS = 5'h0e;
   localparam logic [4:0] STEP_NV_CSUM = 5'h0f;
   localparam logic [4:0] STEP_RTC = 5'h10;
   localparam logic [4:0] STEP_TIMECODE = 5'h11;
   localparam logic [4:0] STEP_INPUT_BOARD = 5'h12;
   localparam logic [4:0] STEP_REF_VOLT = 5'h13;
   // in-service checks: base id plus pending index
   localparam logic [4:0] RUN_BASE = 5'h14;
   localparam int RUN_N = 6;
   localparam int RUN_IMAGE_CMP = 0;
   localparam int RUN_FLASH_CSUM = 1;
   localparam int RUN_DATA_CSUM = 2;
   localparam int RUN_NV_CSUM = 3;
   localparam int RUN_DIO = 4;
   localparam int RUN_REF = 5;
   // fault codes raised inside the block
   localparam logic [4:0] FLT_COP_WDOG = 5'h1a;
   localparam logic [4:0] FLT_REBOOT_TIME = 5'h1b;
   // register map, byte addresses
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_ALARM = 4'h8;
   localparam logic [3:0] OFS_LOST = 4'hc;
   localparam int CTRL_TC_FITTED = 0;
   localparam int CTRL_NET_FITTED = 1;
   localparam int CTRL_RESTORE = 2;
   localparam int AL_BATTERY = 0;
   localparam int AL_TIMECODE = 1;
   localparam int AL_NET = 2;
   localparam int AL_LOSS = 3;
   localparam int AL_N = 4;
   localparam int STS_COP_OK = 2;
   localparam int STS_CAUSE_VALID = 3;
   localparam int STS_REPEAT = 4;
   localparam int STS_CAUSE_LSB = 8;
   localparam int EVT_W = 16;
   localparam int EVT_DEPTH = 8;
   localparam logic [15:0] EVT_LOSS_CODE = 16'hffff;
   typedef enum {ST_BOOT, ST_SERVICE, ST_LOCKOUT} state_type;
endpackage : sup_pkg

// ---- verilog/evt_fifo.sv ----
// fast event buffer held in flip-flops
`timescale 1ns/100ps
module evt_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem_reg[rd_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
         end
         if (push && !pop) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else if (pop && !push) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
endmodule : evt_fifo

// ---- verilog/self_test_recovery_supervisor.sv ----
// self-test sequencer, in-service fault recovery and event buffering
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module self_test_recovery_supervisor #(
   parameter int unsigned REBOOT_CYC = 32'(sup_pkg::REBOOT_LIMIT_CYC),
   parameter int unsigned COP_TIMEOUT = 32'(sup_pkg::COP_TIMEOUT_CYC),
   parameter int unsigned NET_TIMEOUT = 32'(sup_pkg::NET_TIMEOUT_CYC),
   parameter int unsigned CHECK_PERIOD = 32'(sup_pkg::CHECK_PERIOD_CYC)
) (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic TEST_REQ,
   output logic [sup_pkg::ID_W-1:0] TEST_ID,
   input wire logic TEST_DONE,
   input wire logic TEST_PASS,
   input wire logic NV_ACCESS,
   input wire logic ACQ_RUN,
   input wire logic ERR_VALID,
   input wire logic [sup_pkg::ID_W-1:0] ERR_CODE,
   input wire logic COP_BEAT,
   input wire logic NET_ALIVE,
   output logic NET_RST,
   output logic RESTART,
   output logic HEALTHY_LED,
   output logic WDOG_CONTACT,
   output logic PROT_ENABLE,
   output logic COP_ENABLE,
   output logic MAINT_WR,
   output logic [sup_pkg::ID_W-1:0] MAINT_CODE,
   input wire logic MAINT_ACK,
   input wire logic EVT_VALID,
   input wire logic [sup_pkg::EVT_W-1:0] EVT_DATA,
   output logic LOG_VALID,
   output logic [sup_pkg::EVT_W-1:0] LOG_DATA,
   input wire logic LOG_READY
);
   import sup_pkg::*;

   state_type state_reg;
   logic [ID_W-1:0] step_reg;
   logic wait_reg;
   logic cop_ok_reg;
   logic [ID_W-1:0] cause_reg;
   logic cause_valid_reg;
   logic repeat_reg;
   logic [19:0] passed_reg;
   logic reboot_act_reg;
   logic [31:0] reboot_cnt_reg;
   logic [RUN_N-1:0] pend_reg;
   logic [RUN_N-1:0] pend_next;
   logic [31:0] period_cnt_reg;
   logic [31:0] cop_cnt_reg;
   logic [31:0] net_cnt_reg;
   logic tc_fit_reg;
   logic net_fit_reg;
   logic [AL_N-1:0] alarm_reg;
   logic [15:0] lost_reg;
   logic loss_pend_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic restore;
   logic wr_ok;
   logic done_ok;
   logic done_bad;
   logic cop_step;
   logic skip_step;
   logic fault;
   logic [ID_W-1:0] fault_code;
   logic fatal;
   logic cop_lost;
   logic net_lost;
   logic reboot_over;
   logic tick;
   logic run_pick;
   logic [2:0] run_idx;
   logic fifo_in_ready;
   logic fifo_in_valid;
   logic [EVT_W-1:0] fifo_in_data;
   logic evt_drop;

   // register slave: one wait cycle, answer on the second edge
   assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_reg;
   assign AVS_READDATA = rdata_reg;
   assign wr_ok = AVS_WRITE && ack_reg && AVS_BYTEENABLE[0];
   assign restore = wr_ok && (AVS_ADDRESS == OFS_CTRL) && AVS_WRITEDATA[CTRL_RESTORE];

   always_ff @(posedge CLK) begin
      if (SRST) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (AVS_READ || AVS_WRITE) && !ack_reg;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         rdata_reg <= '0;
      end else if (AVS_READ && !ack_reg) begin
         rdata_reg <= '0;
         case (AVS_ADDRESS)
            OFS_CTRL: begin
               rdata_reg[CTRL_TC_FITTED] <= tc_fit_reg;
               rdata_reg[CTRL_NET_FITTED] <= net_fit_reg;
            end
            OFS_STATUS: begin
               rdata_reg[1:0] <= 2'(state_reg);
               rdata_reg[STS_COP_OK] <= cop_ok_reg;
               rdata_reg[STS_CAUSE_VALID] <= cause_valid_reg;
               rdata_reg[STS_REPEAT] <= repeat_reg;
               rdata_reg[STS_CAUSE_LSB +: ID_W] <= cause_reg;
            end
            OFS_ALARM: rdata_reg[AL_N-1:0] <= alarm_reg;
            OFS_LOST: rdata_reg[15:0] <= lost_reg;
            default: rdata_reg <= '0;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         tc_fit_reg <= 1'b0;
         net_fit_reg <= 1'b0;
      end else if (wr_ok && AVS_ADDRESS == OFS_CTRL) begin
         tc_fit_reg <= AVS_WRITEDATA[CTRL_TC_FITTED];
         net_fit_reg <= AVS_WRITEDATA[CTRL_NET_FITTED];
      end
   end

   // test results and step classification
   assign done_ok = wait_reg && TEST_DONE && TEST_PASS;
   assign done_bad = wait_reg && TEST_DONE && !TEST_PASS;
   assign cop_step = (step_reg >= STEP_COP_PRESENT) && (step_reg <= STEP_COP_CHANNELS);
   assign skip_step = (cop_step && !cop_ok_reg) || (step_reg == STEP_TIMECODE && !tc_fit_reg);
   assign reboot_over = reboot_act_reg && (reboot_cnt_reg >= REBOOT_CYC - 1);
   assign tick = (period_cnt_reg >= CHECK_PERIOD - 1);
   assign cop_lost = (state_reg == ST_SERVICE) && cop_ok_reg && (cop_cnt_reg >= COP_TIMEOUT - 1);
   assign net_lost = (state_reg == ST_SERVICE) && net_fit_reg && (net_cnt_reg >= NET_TIMEOUT - 1);

   // in-service errors: failed check, reported error, lost heartbeat
   always_comb begin
      fault = 1'b0;
      fault_code = '0;
      if (state_reg == ST_SERVICE) begin
         if (done_bad) begin
            fault = 1'b1;
            fault_code = TEST_ID;
         end else if (cop_lost) begin
            fault = 1'b1;
            fault_code = FLT_COP_WDOG;
         end else if (ERR_VALID) begin
            fault = 1'b1;
            fault_code = ERR_CODE;
         end
      end
   end
   assign fatal = fault && (fault_code != STEP_BATTERY) && (fault_code != STEP_TIMECODE);

   always_ff @(posedge CLK) begin
      if (SRST || tick || state_reg != ST_SERVICE) begin
         period_cnt_reg <= '0;
      end else begin
         period_cnt_reg <= period_cnt_reg + 1'b1;
      end
   end

   always_comb begin
      run_pick = 1'b0;
      run_idx = '0;
      for (int i = RUN_N - 1; i >= 0; i--) begin
         if (pend_reg[i]) begin
            run_pick = 1'b1;
            run_idx = 3'(i);
         end
      end
   end

   always_comb begin
      pend_next = pend_reg;
      if (state_reg == ST_SERVICE && !wait_reg && run_pick) begin
         pend_next[run_idx] = 1'b0;
      end
      if (tick) begin
         pend_next[RUN_IMAGE_CMP] = 1'b1;
         pend_next[RUN_FLASH_CSUM] = 1'b1;
         pend_next[RUN_DATA_CSUM] = 1'b1;
      end
      if (NV_ACCESS) begin
         pend_next[RUN_NV_CSUM] = 1'b1;
      end
      if (ACQ_RUN) begin
         pend_next[RUN_DIO] = 1'b1;
         pend_next[RUN_REF] = 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST || state_reg != ST_SERVICE) begin
         pend_reg <= '0;
      end else begin
         pend_reg <= pend_next;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST || COP_BEAT || cop_lost || state_reg != ST_SERVICE) begin
         cop_cnt_reg <= '0;
      end else begin
         cop_cnt_reg <= cop_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         net_cnt_reg <= '0;
         NET_RST <= 1'b0;
      end else begin
         NET_RST <= net_lost;
         if (NET_ALIVE || net_lost || state_reg != ST_SERVICE) begin
            net_cnt_reg <= '0;
         end else begin
            net_cnt_reg <= net_cnt_reg + 1'b1;
         end
      end
   end

   // sticky alarms, set wins over write-one-to-clear
   always_ff @(posedge CLK) begin
      if (SRST) begin
         alarm_reg <= '0;
      end else begin
         for (int i = 0; i < AL_N; i++) begin
            if (wr_ok && AVS_ADDRESS == OFS_ALARM && AVS_WRITEDATA[i]) begin
               alarm_reg[i] <= 1'b0;
            end
         end
         if (fault && fault_code == STEP_BATTERY) begin
            alarm_reg[AL_BATTERY] <= 1'b1;
         end
         if (fault && fault_code == STEP_TIMECODE) begin
            alarm_reg[AL_TIMECODE] <= 1'b1;
         end
         if (net_lost) begin
            alarm_reg[AL_NET] <= 1'b1;
         end
         if (evt_drop) begin
            alarm_reg[AL_LOSS] <= 1'b1;
         end
      end
   end

   // main sequencer
   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_reg <= ST_BOOT;
         step_reg <= STEP_FLASH_CSUM;
         wait_reg <= 1'b0;
         TEST_REQ <= 1'b0;
         TEST_ID <= '0;
         cop_ok_reg <= 1'b1;
         repeat_reg <= 1'b0;
         RESTART <= 1'b0;
      end else begin
         TEST_REQ <= 1'b0;
         RESTART <= 1'b0;
         case (state_reg)
            ST_BOOT: begin
               if (reboot_over) begin
                  state_reg <= ST_LOCKOUT;
                  wait_reg <= 1'b0;
               end else if (!wait_reg) begin
                  if (skip_step) begin
                     step_reg <= step_reg + 1'b1;
                  end else begin
                     TEST_REQ <= 1'b1;
                     TEST_ID <= step_reg;
                     wait_reg <= 1'b1;
                  end
               end else if (done_ok) begin
                  wait_reg <= 1'b0;
                  if (step_reg == STEP_REF_VOLT) begin
                     state_reg <= ST_SERVICE;
                  end else begin
                     step_reg <= step_reg + 1'b1;
                  end
               end else if (done_bad) begin
                  wait_reg <= 1'b0;
                  if (cop_step) begin
                     cop_ok_reg <= 1'b0;
                     step_reg <= STEP_NV_CSUM;
                  end else begin
                     state_reg <= ST_LOCKOUT;
                     repeat_reg <= cause_valid_reg && (cause_reg == step_reg);
                  end
               end
            end
            ST_SERVICE: begin
               if (fatal) begin
                  state_reg <= ST_BOOT;
                  step_reg <= STEP_FLASH_CSUM;
                  wait_reg <= 1'b0;
                  cop_ok_reg <= 1'b1;
                  RESTART <= 1'b1;
               end else if (wait_reg) begin
                  if (TEST_DONE) begin
                     wait_reg <= 1'b0;
                  end
               end else if (run_pick) begin
                  TEST_REQ <= 1'b1;
                  TEST_ID <= RUN_BASE + ID_W'(run_idx);
                  wait_reg <= 1'b1;
               end
            end
            ST_LOCKOUT: begin
               if (restore) begin
                  state_reg <= ST_BOOT;
                  step_reg <= STEP_FLASH_CSUM;
                  cop_ok_reg <= 1'b1;
                  repeat_reg <= 1'b0;
               end
            end
            default: state_reg <= ST_LOCKOUT;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         cause_reg <= '0;
         cause_valid_reg <= 1'b0;
      end else if (fatal) begin
         cause_reg <= fault_code;
         cause_valid_reg <= 1'b1;
      end else if (reboot_over) begin
         cause_reg <= FLT_REBOOT_TIME;
      end else if (restore && state_reg == ST_LOCKOUT) begin
         cause_valid_reg <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST || state_reg != ST_BOOT || reboot_over) begin
         reboot_act_reg <= fatal && !SRST;
         reboot_cnt_reg <= '0;
      end else if (reboot_act_reg) begin
         reboot_cnt_reg <= reboot_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST || TEST_REQ && TEST_ID == STEP_FLASH_CSUM) begin
         passed_reg <= '0;
      end else if (state_reg == ST_BOOT && done_ok) begin
         passed_reg[step_reg] <= 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         MAINT_WR <= 1'b0;
         MAINT_CODE <= '0;
      end else if (fault || (state_reg == ST_BOOT && done_bad)) begin
         MAINT_WR <= 1'b1;
         MAINT_CODE <= fault ? fault_code : step_reg;
      end else if (reboot_over) begin
         MAINT_WR <= 1'b1;
         MAINT_CODE <= FLT_REBOOT_TIME;
      end else if (MAINT_ACK) begin
         MAINT_WR <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         HEALTHY_LED <= 1'b0;
         WDOG_CONTACT <= 1'b1;
         PROT_ENABLE <= 1'b0;
         COP_ENABLE <= 1'b0;
      end else begin
         HEALTHY_LED <= (state_reg == ST_SERVICE) && !fatal;
         WDOG_CONTACT <= (state_reg != ST_SERVICE) || fatal;
         PROT_ENABLE <= (state_reg == ST_SERVICE) && !fatal;
         COP_ENABLE <= (state_reg == ST_SERVICE) && !fatal && cop_ok_reg;
      end
   end

   // events into the fast buffer; loss marker first
   assign fifo_in_valid = loss_pend_reg || EVT_VALID;
   assign fifo_in_data = loss_pend_reg ? EVT_LOSS_CODE : EVT_DATA;
   assign evt_drop = EVT_VALID && (!fifo_in_ready || loss_pend_reg);

   always_ff @(posedge CLK) begin
      if (SRST) begin
         loss_pend_reg <= 1'b0;
         lost_reg <= '0;
      end else begin
         if (evt_drop) begin
            loss_pend_reg <= 1'b1;
            lost_reg <= lost_reg + 1'b1;
         end else if (loss_pend_reg && fifo_in_ready) begin
            loss_pend_reg <= 1'b0;
         end
      end
   end

   evt_fifo #(.W(EVT_W), .DEPTH(EVT_DEPTH)) u_evt_fifo (
      .clk(CLK),
      .srst(SRST),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(LOG_VALID),
      .out_ready(LOG_READY),
      .out_data(LOG_DATA)
   );

   sequence s_req(logic [4:0] id);
      TEST_REQ && TEST_ID == id;
   endsequence

   chk_copy_after_csum: assert property (@(posedge CLK) disable iff (SRST)
      s_req(STEP_IMAGE_COPY) |-> passed_reg[STEP_FLASH_CSUM])
      else $error("image copy before flash checksum");
   chk_entry_after_verify: assert property (@(posedge CLK) disable iff (SRST)
      s_req(STEP_WDOG_START) |-> passed_reg[STEP_COPY_VERIFY])
      else $error("entry before copy verify");
   chk_wdog_first: assert property (@(posedge CLK) disable iff (SRST)
      s_req(STEP_BATTERY) |-> passed_reg[STEP_WDOG_START])
      else $error("init checks before watchdog start");
   chk_cop_code_order: assert property (@(posedge CLK) disable iff (SRST)
      s_req(STEP_COP_XFER) |-> passed_reg[STEP_COP_RAM] && passed_reg[STEP_COP_CSUM_PRE])
      else $error("co-processor transfer out of order");
   chk_healthy_service: assert property (@(posedge CLK) disable iff (SRST)
      HEALTHY_LED |-> $past(state_reg == ST_SERVICE) && PROT_ENABLE)
      else $error("healthy outside service");
   chk_lockout_holds: assert property (@(posedge CLK) disable iff (SRST)
      state_reg == ST_LOCKOUT && !restore |=> state_reg == ST_LOCKOUT)
      else $error("lockout left without restore");
   chk_nonfatal_runs: assert property (@(posedge CLK) disable iff (SRST)
      fault && !fatal && state_reg == ST_SERVICE |=> state_reg == ST_SERVICE)
      else $error("non-fatal error left service");
   chk_fatal_reboot: assert property (@(posedge CLK) disable iff (SRST)
      fatal |=> RESTART && state_reg == ST_BOOT ##1 WDOG_CONTACT && !HEALTHY_LED)
      else $error("fatal error without reboot");
   chk_lockout_pins: assert property (@(posedge CLK) disable iff (SRST)
      state_reg == ST_LOCKOUT [*2] |-> WDOG_CONTACT && !HEALTHY_LED)
      else $error("lockout indicators wrong");
   chk_net_reset: assert property (@(posedge CLK) disable iff (SRST)
      net_lost |=> NET_RST && alarm_reg[AL_NET])
      else $error("network board not reset");
   chk_loss_marked: assert property (@(posedge CLK) disable iff (SRST)
      evt_drop |=> loss_pend_reg ##[0:64] (loss_pend_reg && fifo_in_ready) || !LOG_READY)
      else $error("loss event not queued");
   chk_maint_record: assert property (@(posedge CLK) disable iff (SRST)
      fault |=> MAINT_WR && MAINT_CODE == $past(fault_code))
      else $error("no maintenance record");
endmodule : self_test_recovery_supervisor

// ---- dv/far_side.sv ----
// far-side model: test runner, record store, co-processor and network heartbeats
`timescale 1ns/100ps
module far_side (
   input wire logic clk,
   input wire logic test_req,
   input wire logic [4:0] test_id,
   input wire logic [4:0] fail_id,
   input wire logic maint_wr,
   output logic test_done = 1'b0,
   output logic test_pass = 1'b0,
   output logic maint_ack = 1'b0,
   output logic cop_beat = 1'b0,
   output logic net_alive = 1'b0
);
   logic [4:0] beat_cnt = 5'h00;
   logic [4:0] id_reg = 5'h00;
   logic [1:0] due = 2'h0;
   // answers after two or three cycles; pass level toggles when not qualified
   always @(posedge clk) begin
      test_done <= 1'b0;
      test_pass <= ~test_pass;
      beat_cnt <= beat_cnt + 5'h01;
      cop_beat <= beat_cnt == 5'h00;
      net_alive <= beat_cnt == 5'h00;
      maint_ack <= maint_wr && !maint_ack;
      if (test_req) begin
         id_reg <= test_id;
         due <= {1'b1, test_id[0]};
      end else if (due != 2'h0) begin
         due <= due - 2'h1;
         if (due == 2'h1) begin
            test_done <= 1'b1;
            test_pass <= id_reg != fail_id;
         end
      end
   end
endmodule : far_side

// ---- dv/tb_top.sv ----
// bench: boot order, in-service errors, event loss and lockout
`timescale 1ns/100ps
module tb_top;
   import sup_pkg::*;
   logic clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, errv = 1'b0, evv = 1'b0, rdy = 1'b0;
   logic nv = 1'b0, acq = 1'b0;
   logic [31:0] seen = 32'h0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0, rdq, rdata;
   logic [4:0] ecode = 5'h00, fail = 5'h1f, tid, mcode, exp_id = 5'h00;
   logic [15:0] evd = 16'h0, ldat;
   logic treq, td, tp, cb, na, nrst, rso, led, wdog, prot, cope, mwr, mack, lval, wreq;
   int errors = 0, total_checks = 0, nreq = 0, i;
   always #2.5 clk = ~clk;
   self_test_recovery_supervisor #(.REBOOT_CYC(200), .COP_TIMEOUT(50), .NET_TIMEOUT(50),
      .CHECK_PERIOD(100)) DUT (.CLK(clk), .SRST(srst), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdq),
      .AVS_WAITREQUEST(wreq), .TEST_REQ(treq), .TEST_ID(tid), .TEST_DONE(td), .TEST_PASS(tp),
      .NV_ACCESS(nv), .ACQ_RUN(acq), .ERR_VALID(errv), .ERR_CODE(ecode), .COP_BEAT(cb),
      .NET_ALIVE(na), .NET_RST(nrst), .RESTART(rso), .HEALTHY_LED(led), .WDOG_CONTACT(wdog),
      .PROT_ENABLE(prot), .COP_ENABLE(cope), .MAINT_WR(mwr), .MAINT_CODE(mcode),
      .MAINT_ACK(mack), .EVT_VALID(evv), .EVT_DATA(evd), .LOG_VALID(lval), .LOG_DATA(ldat),
      .LOG_READY(rdy));
   far_side far (.clk(clk), .test_req(treq), .test_id(tid), .fail_id(fail), .maint_wr(mwr),
      .test_done(td), .test_pass(tp), .maint_ack(mack), .cop_beat(cb), .net_alive(na));
   task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask : cmp
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      do @(posedge clk); while (wreq);
      rdata = rdq;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic err(input logic [4:0] c);
      @(posedge clk);
      errv <= 1'b1;
      ecode <= c;
      @(posedge clk);
      errv <= 1'b0;
   endtask : err
   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict
   always @(negedge clk) if (treq && nreq < 19) begin
      cmp("boot id", exp_id, tid);
      nreq++;
      exp_id = (exp_id == 5'h10) ? 5'h12 : exp_id + 5'h01;
   end
   always @(negedge clk) if (treq) seen[tid] = 1'b1;
   initial begin
      #20000;
      errors++;
      print_verdict;
   end
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      for (i = 0; i < 400 && led !== 1'b1; i++) @(posedge clk);
      cmp("boot count", 19, nreq);
      cmp("prot", 1, prot);
      err(5'h04);
      for (i = 0; i < 10 && mwr !== 1'b1; i++) @(negedge clk);
      cmp("maint code", 5'h04, mcode);
      for (i = 0; i < 10; i++) begin
         @(posedge clk);
         evv <= 1'b1;
         evd <= 16'(i);
      end
      @(posedge clk);
      evv <= 1'b0;
      bus(1'b0, OFS_LOST, 32'h0);
      cmp("lost", 2, rdata);
      bus(1'b0, OFS_ALARM, 32'h0);
      cmp("alarm", 32'h9, rdata & 32'hf);
      cmp("healthy", 1, led);
      @(posedge clk);
      rdy <= 1'b1;
      for (i = 0; i < 9; i++) begin
         @(negedge clk);
         cmp("log", {16'h1, (i < 8) ? 16'(i) : EVT_LOSS_CODE}, {15'h0, lval, ldat});
      end
      @(posedge clk);
      rdy <= 1'b0;
      cmp("queued", 0, seen[25:23]);
      nv <= 1'b1;
      acq <= 1'b1;
      @(posedge clk);
      nv <= 1'b0;
      acq <= 1'b0;
      repeat (150) @(posedge clk);
      cmp("service ids", 32'h3f, seen[25:20]);
      fail <= 5'h05;
      err(5'h05);
      for (i = 0; i < 5 && rso !== 1'b1; i++) @(negedge clk);
      cmp("restart", 1, rso);
      @(negedge clk);
      cmp("outputs", 32'h2, {led, wdog, prot});
      for (i = 0; i < 60 && rdata[1:0] !== 2'h2; i++) bus(1'b0, OFS_STATUS, 32'h0);
      cmp("status", 32'h51a, rdata & 32'h1f1b);
      cmp("lockout", 32'h1, {led, wdog});
      fail <= 5'h1f;
      bus(1'b1, OFS_CTRL, 32'h4);
      for (i = 0; i < 400 && led !== 1'b1; i++) @(posedge clk);
      bus(1'b0, OFS_STATUS, 32'h0);
      cmp("restored", 32'h5, rdata & 32'h1f);
      cmp("cop enable", 1, cope);
      print_verdict;
   end
endmodule : tb_top
